// [sync_delay_regs.svh]
// Register offsets, field positions, reset values and timing counts for
// the sync delay and test pattern size block.
// Assumes an APB slave with 32-bit data; each register is one aligned word.
// What this block does
// - Join two fields into 12-bit first pattern size
// - Pattern sizes only drive the test pattern
// - Second pattern size used only in split mode
// - Delay syncs by programmed 12-bit pixel clock count
// - First delay on A; also B in modes 00/01
// - Programmed delay adds to about ten clock latency
// - Delay upper nibble from next register bits 3-0
`ifndef SYNC_DELAY_REGS_SVH
`define SYNC_DELAY_REGS_SVH

// Register indices; the byte address is four times the index
`define IDX_PATTERN_FIRST_LOW   8'h24
`define IDX_PATTERN_FIRST_HIGH  8'h25
`define IDX_PATTERN_SECOND_LOW  8'h26
`define IDX_PATTERN_SECOND_HIGH 8'h27
`define IDX_SYNC_HOLD_LOW       8'h28
`define IDX_SYNC_HOLD_HIGH      8'h29
`define IDX_MODE_CTRL           8'h2E
`define IDX_STATUS              8'h2F

// Field positions
`define LOW_MSB                 7
`define HIGH_MSB                3
`define CTRL_TEST_EN_BIT        0
`define CTRL_SINGLE_BIT         4
`define CTRL_MODE_LSB           5
`define CTRL_MODE_MSB           6
`define STAT_BELOW_MIN_BIT      0
`define STAT_B_FOLLOWS_BIT      1
`define STAT_SPLIT_BIT          2

// Reset values
`define RST_LOW                 8'h00
`define RST_HIGH                4'h0
`define RST_MODE                2'h0

// Timing counts in pixel clocks
`define SYNC_PIPE_CLOCKS        10
`define SYNC_MIN_CLOCKS         12'h020

`endif

// [sync_delay_pkg.sv]
// Types shared by the sync delay and test pattern size block.
// Assumes nothing beyond a SystemVerilog compiler.
package sync_delay_pkg;

    typedef enum logic [1:0]
    {
        CHAN_MODE_ZERO  = 2'b00,
        CHAN_MODE_ONE   = 2'b01,
        CHAN_MODE_SPLIT = 2'b10,
        CHAN_MODE_RSVD  = 2'b11
    } chan_mode_t;

endpackage

// [sync_hold_line.sv]
// Programmable delay line for one channel's sync pair.
// Assumes sync inputs come from logic on the same pixel clock.
`timescale 1ns/1ps
`default_nettype none

module sync_hold_line #(
    parameter int AW    = 12,
    parameter int WIDTH = 2,
    parameter int PIPE  = 9
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Control
    input  wire logic             en_i,
    input  wire logic [AW-1:0]    delay_i,
    // Syncs
    input  wire logic [WIDTH-1:0] sync_i,
    output logic      [WIDTH-1:0] sync_o
);

    localparam int DEPTH = 1 << AW;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [WIDTH-1:0] buf_q;
    logic [WIDTH-1:0] pipe_q [PIPE];
    logic [AW:0]      stable_q;

    always_ff @(posedge clk_i)
    begin
        mem[wr_ptr_q] <= sync_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            wr_ptr_q <= '0;
        else
            wr_ptr_q <= wr_ptr_q + 1'b1;
    end

    // Zero delay bypasses the memory since the slot is written this edge
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            buf_q <= '0;
        else if (delay_i == '0)
            buf_q <= sync_i;
        else
            buf_q <= mem[wr_ptr_q - delay_i];
    end

    // Fixed pipeline stands for the inherent path latency
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            pipe_q[0] <= '0;
        else
            pipe_q[0] <= buf_q;
    end

    for (genvar i = 1; i < PIPE; i++)
    begin : g_pipe
        always_ff @(posedge clk_i)
        begin
            if (sys_rst_i)
                pipe_q[i] <= '0;
            else
                pipe_q[i] <= pipe_q[i-1];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            sync_o <= '0;
        else
            sync_o <= en_i ? pipe_q[PIPE-1] : '0;
    end

    // Cycles since the delay last changed, for checking only
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || delay_i != $past(delay_i))
            stable_q <= '0;
        else if (stable_q != '1)
            stable_q <= stable_q + 1'b1;
    end

    chk_zero_bypass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        delay_i == '0 |=> buf_q == $past(sync_i))
        else $error("zero delay did not bypass the memory");

    chk_delay_min: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (stable_q > 34 && delay_i == 32) |-> buf_q == $past(sync_i, 33))
        else $error("sync not held back by 32 clocks");

    // Held off until the slot read back was written since reset or change
    chk_pipe_latency: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $past(en_i) && stable_q > {1'b0, delay_i} + 13'h00C
            |-> sync_o == $past(buf_q, 10))
        else $error("inherent pipeline latency wrong");

    chk_idle_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !en_i |=> sync_o == '0)
        else $error("disabled channel drove syncs");

    cov_delay_min: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        stable_q > 34 && delay_i == 32 && buf_q != '0);

endmodule

`default_nettype wire

// [sync_delay_top.sv]
// Sync delay and test pattern vertical size registers with APB access.
// Assumes APB master and sync sources on the same pixel clock.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sync_delay_regs.svh"

module sync_delay_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Video syncs, bit 0 horizontal, bit 1 vertical
    input  wire logic [1:0]  sync_a_i,
    input  wire logic [1:0]  sync_b_i,
    input  wire logic [11:0] sync_hold_second_i,
    output logic      [1:0]  sync_a_o,
    output logic      [1:0]  sync_b_o,
    // Test pattern generator sizes
    output logic      [11:0] pattern_lines_a_o,
    output logic      [11:0] pattern_lines_b_o
);

    logic [7:0]                  pattern_first_low_q;
    logic [3:0]                  pattern_first_high_q;
    logic [7:0]                  pattern_second_low_q;
    logic [3:0]                  pattern_second_high_q;
    logic [7:0]                  sync_hold_first_low_q;
    logic [3:0]                  sync_hold_first_high_q;
    logic                        test_en_q;
    logic                        single_q;
    sync_delay_pkg::chan_mode_t  mode_q;
    logic [11:0]                 pattern_first;
    logic [11:0]                 pattern_second;
    logic [11:0]                 delay_a;
    logic [11:0]                 delay_b;
    logic                        b_follows_a;
    logic                        split;
    logic                        below_min;
    logic                        setup;
    logic                        wr_en;
    logic                        aligned;
    logic [7:0]                  idx;
    logic                        hit;
    logic [31:0]                 rdata_d;

    assign pattern_first  = {pattern_first_high_q, pattern_first_low_q};
    assign pattern_second = {pattern_second_high_q, pattern_second_low_q};
    assign delay_a = {sync_hold_first_high_q, sync_hold_first_low_q};
    assign split   = mode_q == sync_delay_pkg::CHAN_MODE_SPLIT;
    assign b_follows_a = !single_q
        && (mode_q == sync_delay_pkg::CHAN_MODE_ZERO
        || mode_q == sync_delay_pkg::CHAN_MODE_ONE);
    assign delay_b = b_follows_a ? delay_a : sync_hold_second_i;
    // Short delays are legal to write but flagged for software
    assign below_min = delay_a < `SYNC_MIN_CLOCKS;

    assign setup   = psel_i && !penable_i;
    assign wr_en   = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
    assign aligned = paddr_i[11:10] == 2'h0 && paddr_i[1:0] == 2'h0;
    assign idx     = paddr_i[9:2];

    // Reserved bits read as zero
    always_comb
    begin
        hit     = aligned;
        rdata_d = 32'h0000_0000;
        case (idx)
            `IDX_PATTERN_FIRST_LOW:   rdata_d[7:0] = pattern_first_low_q;
            `IDX_PATTERN_FIRST_HIGH:  rdata_d[3:0] = pattern_first_high_q;
            `IDX_PATTERN_SECOND_LOW:  rdata_d[7:0] = pattern_second_low_q;
            `IDX_PATTERN_SECOND_HIGH: rdata_d[3:0] = pattern_second_high_q;
            `IDX_SYNC_HOLD_LOW:       rdata_d[7:0] = sync_hold_first_low_q;
            `IDX_SYNC_HOLD_HIGH:      rdata_d[3:0] = sync_hold_first_high_q;
            `IDX_MODE_CTRL:
            begin
                rdata_d[`CTRL_TEST_EN_BIT] = test_en_q;
                rdata_d[`CTRL_SINGLE_BIT]  = single_q;
                rdata_d[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = mode_q;
            end
            `IDX_STATUS:
            begin
                rdata_d[`STAT_BELOW_MIN_BIT] = below_min;
                rdata_d[`STAT_B_FOLLOWS_BIT] = b_follows_a;
                rdata_d[`STAT_SPLIT_BIT]     = split;
            end
            default:                  hit = 1'b0;
        endcase
        if (!aligned)
            rdata_d = 32'h0000_0000;
    end

    // No wait state: the answer is registered in the setup cycle, so every answer comes from a flip-flop
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= setup;
            pslverr_o <= setup && !hit;
            prdata_o  <= (setup && !pwrite_i) ? rdata_d : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pattern_first_low_q   <= `RST_LOW;
            pattern_first_high_q  <= `RST_HIGH;
            pattern_second_low_q  <= `RST_LOW;
            pattern_second_high_q <= `RST_HIGH;
        end
        else if (wr_en && aligned)
        begin
            if (idx == `IDX_PATTERN_FIRST_LOW)
                pattern_first_low_q <= pwdata_i[`LOW_MSB:0];
            if (idx == `IDX_PATTERN_FIRST_HIGH)
                pattern_first_high_q <= pwdata_i[`HIGH_MSB:0];
            if (idx == `IDX_PATTERN_SECOND_LOW)
                pattern_second_low_q <= pwdata_i[`LOW_MSB:0];
            if (idx == `IDX_PATTERN_SECOND_HIGH)
                pattern_second_high_q <= pwdata_i[`HIGH_MSB:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sync_hold_first_low_q  <= `RST_LOW;
            sync_hold_first_high_q <= `RST_HIGH;
        end
        else if (wr_en && aligned)
        begin
            if (idx == `IDX_SYNC_HOLD_LOW)
                sync_hold_first_low_q <= pwdata_i[`LOW_MSB:0];
            if (idx == `IDX_SYNC_HOLD_HIGH)
                sync_hold_first_high_q <= pwdata_i[`HIGH_MSB:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            test_en_q <= 1'b0;
            single_q  <= 1'b0;
            mode_q    <= sync_delay_pkg::chan_mode_t'(`RST_MODE);
        end
        else if (wr_en && aligned && idx == `IDX_MODE_CTRL)
        begin
            test_en_q <= pwdata_i[`CTRL_TEST_EN_BIT];
            single_q  <= pwdata_i[`CTRL_SINGLE_BIT];
            mode_q    <= sync_delay_pkg::chan_mode_t'(
                pwdata_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
        end
    end

    // Sizes reach only the pattern generator, zero outside test mode
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pattern_lines_a_o <= 12'h000;
            pattern_lines_b_o <= 12'h000;
        end
        else
        begin
            pattern_lines_a_o <= test_en_q ? pattern_first : 12'h000;
            pattern_lines_b_o <= !test_en_q ? 12'h000
                : split ? pattern_second : pattern_first;
        end
    end

    sync_hold_line #(
        .AW    (12),
        .WIDTH (2),
        .PIPE  (`SYNC_PIPE_CLOCKS - 1)
    ) u_line_a (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (1'b1),
        .delay_i   (delay_a),
        .sync_i    (sync_a_i),
        .sync_o    (sync_a_o)
    );

    // Channel B is dark while only one output channel is in use
    sync_hold_line #(
        .AW    (12),
        .WIDTH (2),
        .PIPE  (`SYNC_PIPE_CLOCKS - 1)
    ) u_line_b (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (!single_q),
        .delay_i   (delay_b),
        .sync_i    (sync_b_i),
        .sync_o    (sync_b_o)
    );

    chk_first_join: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        test_en_q |=> pattern_lines_a_o
            == {$past(pattern_first_high_q), $past(pattern_first_low_q)})
        else $error("first pattern size not joined from its fields");

    chk_pattern_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !test_en_q |=> pattern_lines_a_o == 12'h000
            && pattern_lines_b_o == 12'h000)
        else $error("pattern size leaked outside test mode");

    chk_second_size: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        test_en_q && !split |=> pattern_lines_b_o == $past(pattern_first))
        else $error("second size used outside split mode");

    chk_b_follows_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !single_q && !split && mode_q != sync_delay_pkg::CHAN_MODE_RSVD
            |-> u_line_b.delay_i == delay_a)
        else $error("channel B not using the first delay");

    chk_low_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_en && aligned && idx == `IDX_SYNC_HOLD_LOW
            |=> delay_a[7:0] == $past(pwdata_i[7:0]))
        else $error("delay low byte write lost");

    chk_upper_nibble: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_en && aligned && idx == `IDX_SYNC_HOLD_HIGH
            |=> delay_a[11:8] == $past(pwdata_i[3:0]) && $stable(delay_a[7:0]))
        else $error("delay upper nibble write wrong");

    cov_split_test: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        test_en_q && split ##1 pattern_lines_b_o != 12'h000);
    cov_b_follows: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        b_follows_a && !below_min && sync_b_o != 2'h0);
    cov_single: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        single_q && sync_a_o != 2'h0);

endmodule

`default_nettype wire

// [sync_src_model.sv]
// Sync source standing in for the serial video input of both channels.
// Assumes the pixel clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module sync_src_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Syncs, bit 0 horizontal, bit 1 vertical
    output logic      [1:0] sync_a_o,
    output logic      [1:0] sync_b_o
);
    int cnt_q;

    // Unrelated periods on the two channels, so swapped paths show up
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q    <= 0;
            sync_a_o <= 2'b00;
            sync_b_o <= 2'b00;
        end
        else
        begin
            cnt_q    <= cnt_q + 1;
            sync_a_o <= {cnt_q % 611 < 20, cnt_q % 37 < 3};
            sync_b_o <= {cnt_q % 433 < 9, cnt_q % 29 < 2};
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the sync delay and pattern size block.
// Assumes the design files and sync_src_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sync_delay_regs.svh"

module tb;
    localparam int M = 8191;
    localparam int DA [5] = '{32, 320, 45, 50, 32};
    localparam int DB [5] = '{40, 40, 33, 60, 40};
    localparam int MD [5] = '{0, 1, 2, 3, 0};
    localparam int SG [5] = '{0, 0, 0, 0, 1};
    logic        clk_i;
    logic        sys_rst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [3:0]  pstrb_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [1:0]  sa;
    logic [1:0]  sb;
    logic [11:0] sync_hold_second_i;
    logic [1:0]  sync_a_o;
    logic [1:0]  sync_b_o;
    logic [11:0] pattern_lines_a_o;
    logic [11:0] pattern_lines_b_o;
    logic [1:0]  ha [0:M];
    logic [1:0]  hb [0:M];
    logic [1:0]  eb;
    logic [1:0]  mode_v;
    logic        single_v;
    logic [31:0] rd;
    logic [31:0] st_e;
    logic        err;
    int          cyc;
    int          chk_from;
    int          da;
    int          n_errors;
    int          n_tests;

    sync_delay_top u_sync_delay_top (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .sync_a_i(sa),
        .sync_b_i(sb), .sync_hold_second_i(sync_hold_second_i),
        .sync_a_o(sync_a_o), .sync_b_o(sync_b_o),
        .pattern_lines_a_o(pattern_lines_a_o),
        .pattern_lines_b_o(pattern_lines_b_o));

    sync_src_model u_sync_src_model (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sync_a_o(sa), .sync_b_o(sb));

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    function automatic logic [31:0] ctrl(input logic [1:0] m,
                                         input logic s, input logic t);
        return {25'h0, m, s, 3'h0, t};
    endfunction

    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic chk_sync(input string nm, input logic [1:0] e,
                            input logic [1:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask

    // Waits for pready rather than assuming the one-cycle answer
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        pstrb_i   <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        if (n >= 20)
            n_errors++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cyc++;
        ha[cyc & M] = sa;
        hb[cyc & M] = sb;
    end

    // Outputs are checked against the input history at the set lag
    always @(negedge clk_i)
    begin
        if (!sys_rst_i && cyc >= chk_from)
        begin
            if (single_v)
                eb = 2'b00;
            else if (mode_v[1])
                eb = hb[(cyc - int'(sync_hold_second_i) - 10) & M];
            else
                eb = hb[(cyc - da - 10) & M];
            chk_sync("sync_a_o", ha[(cyc - da - 10) & M], sync_a_o);
            chk_sync("sync_b_o", eb, sync_b_o);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        final_report();
    end

    initial
    begin
        cyc = 0;
        chk_from = 1 << 30;
        n_errors = 0;
        n_tests = 0;
        sys_rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i} = 3'b000;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        pstrb_i = 4'h0;
        sync_hold_second_i = 12'h028;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        chk_word("pattern_a", 32'h0, {20'h0, pattern_lines_a_o});
        xfer(1'b0, ba(`IDX_STATUS), 32'h0, 4'h0);
        chk_word("status", 32'h3, rd);
        for (int i = 0; i < 6; i++)
        begin
            xfer(1'b0, 12'h090 + 12'(4 * i), 32'h0, 4'h0);
            chk_word("reset value", 32'h0, rd);
            wr(12'h090 + 12'(4 * i), 32'hFFFF_FFFF);
            chk_word("write err", 32'h0, {31'h0, err});
            xfer(1'b0, 12'h090 + 12'(4 * i), 32'h0, 4'h0);
            chk_word("rw value", i[0] ? 32'hF : 32'hFF, rd);
        end
        xfer(1'b0, 12'h400, 32'h0, 4'h0);
        chk_word("unmapped err", 32'h1, {31'h0, err});
        xfer(1'b1, 12'h091, 32'h0, 4'hF);
        chk_word("unaligned err", 32'h1, {31'h0, err});
        xfer(1'b1, ba(`IDX_PATTERN_FIRST_LOW), 32'h55, 4'h0);
        xfer(1'b0, ba(`IDX_PATTERN_FIRST_LOW), 32'h0, 4'h0);
        chk_word("strobe off", 32'hFF, rd);
        wr(ba(`IDX_PATTERN_FIRST_LOW), 32'hA3);
        wr(ba(`IDX_PATTERN_FIRST_HIGH), 32'h05);
        wr(ba(`IDX_PATTERN_SECOND_LOW), 32'hC7);
        wr(ba(`IDX_PATTERN_SECOND_HIGH), 32'h03);
        @(negedge clk_i);
        chk_word("pattern off", 32'h0, {20'h0, pattern_lines_a_o});
        for (int m = 0; m < 4; m++)
        begin
            wr(ba(`IDX_MODE_CTRL), ctrl(2'(m), 1'b0, 1'b1));
            repeat (2) @(negedge clk_i);
            chk_word("pattern_a", 32'h5A3, {20'h0, pattern_lines_a_o});
            chk_word("pattern_b", m == 2 ? 32'h3C7 : 32'h5A3,
                     {20'h0, pattern_lines_b_o});
        end
        for (int i = 0; i < 5; i++)
        begin
            chk_from = 1 << 30;
            da = DA[i];
            sync_hold_second_i <= 12'(DB[i]);
            wr(ba(`IDX_SYNC_HOLD_LOW), 32'(da & 255));
            wr(ba(`IDX_SYNC_HOLD_HIGH), 32'(da >> 8));
            mode_v = 2'(MD[i]);
            single_v = SG[i][0];
            wr(ba(`IDX_MODE_CTRL), ctrl(mode_v, single_v, 1'b1));
            xfer(1'b0, ba(`IDX_STATUS), 32'h0, 4'h0);
            st_e = {29'h0, mode_v == 2'b10, !single_v && !mode_v[1], 1'b0};
            chk_word("status", st_e, rd);
            chk_from = cyc + 350;
            repeat (400) @(posedge clk_i);
            wr(ba(`IDX_PATTERN_FIRST_LOW), 32'(i));
            repeat (300) @(posedge clk_i);
        end
        final_report();
    end
endmodule
`default_nettype wire
